/* rtl/ela_pkg.sv */
// Package for the embedded logic analyzer capture block.
// Assumes a single clock domain and an APB register bus with 32-bit data.
package ela_pkg;

	// ********************************************************
	// Widths and depths
	// ********************************************************
	localparam int TRIG_W      = 40;
	localparam int MON_W       = 32;
	localparam int STIM_W      = 32;
	localparam int STIM_MAX_W  = 512;
	localparam int DEPTH       = 1024;
	localparam int AW          = 10;
	localparam int NSTAGE      = 3;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int CLK_MHZ     = 125;

	// ********************************************************
	// Register byte offsets
	// ********************************************************
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_STATUS   = 12'h004;
	localparam logic [11:0] OFS_PRE      = 12'h008;
	localparam logic [11:0] OFS_STIM     = 12'h00C;
	localparam logic [11:0] OFS_RDIDX    = 12'h010;
	localparam logic [11:0] OFS_RDDATA   = 12'h014;
	localparam logic [11:0] OFS_RDMARK   = 12'h018;
	localparam logic [11:0] OFS_DEPTH    = 12'h01C;
	localparam logic [11:0] OFS_TRIG     = 12'h040;
	localparam int          TRIG_STRIDE  = 32;
	localparam logic [4:0]  TOF_PAT_LO   = 5'h00;
	localparam logic [4:0]  TOF_PAT_HI   = 5'h04;
	localparam logic [4:0]  TOF_EDG_LO   = 5'h08;
	localparam logic [4:0]  TOF_EDG_HI   = 5'h0C;
	localparam logic [4:0]  TOF_CARE_LO  = 5'h10;
	localparam logic [4:0]  TOF_CARE_HI  = 5'h14;

	// ********************************************************
	// Control bit positions and reset values
	// ********************************************************
	localparam int CTRL_ARM_BIT   = 0;
	localparam int CTRL_NSEQ_LSB  = 1;
	localparam int CTRL_OR_LSB    = 4;
	localparam logic [1:0] NSEQ_RST = 2'h1;
	localparam logic [6:0] PRE_RST  = 7'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE,
		ST_ARMED,
		ST_POST,
		ST_DONE
	} ela_state_e;

	typedef struct packed {
		logic [TRIG_W-1:0] pat;
		logic [TRIG_W-1:0] edg;
		logic [TRIG_W-1:0] care;
		logic              use_or;
	} ela_trig_s;

	typedef struct packed {
		logic [MON_W-1:0] data;
		logic             mark;
	} ela_sample_s;

endpackage

/* rtl/ela_stage.sv */
// One trigger stage: per-channel compare and AND/OR combine.
// Assumes the previous trigger sample is supplied for edge detection.
`timescale 1ns/1ns
`default_nettype none
module ela_stage
	import ela_pkg::*;
(
	input  wire logic [TRIG_W-1:0] cur,
	input  wire logic [TRIG_W-1:0] prv,
	input  wire ela_trig_s         cfg,
	output logic                   hit
);
	logic [TRIG_W-1:0] ok;

	always_comb
	begin
		// Edge: pattern 1 rising, 0 falling; level: pattern equals value
		for (int i = 0; i < TRIG_W; i++)
		begin
			if (cfg.edg[i])
				ok[i] = cfg.pat[i] ? (cur[i] & ~prv[i]) : (~cur[i] & prv[i]); // RULE14
			else
				ok[i] = ~(cur[i] ^ cfg.pat[i]); // RULE14
		end
		if (cfg.use_or)
			hit = |(ok & cfg.care); // RULE11
		else
			hit = &(ok | ~cfg.care); // RULE10
	end
endmodule
`default_nettype wire

/* rtl/ela_top.sv */
// Embedded logic analyzer: sequential trigger, pre/post capture, stimulus.
// Assumes probe, trigger and APB signals synchronous to MCLK.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1 - Stimulus width parameter, zero to 512
// RULE2 - Stimulus presented once per arming session
// RULE3 - Stimulus meaningful only while valid high
// RULE4 - Capture never depends on stimulus consumption
// RULE5 - Stimulus port width equals stimulus parameter
// RULE6 - Probe port width equals probe parameter
// RULE7 - Built-in depth governs capture length
// RULE8 - Pre-trigger fraction splits the buffer
// RULE9 - Marker falls low at trigger sample
// RULE10 - AND mode needs all unmasked channels
// RULE11 - OR mode needs any unmasked channel
// RULE12 - Combine mode held per stage
// RULE13 - Stimulus channels are static host levels
// RULE14 - Channel condition: ignore, rise, fall, low, high
// RULE15 - One to three stages, sequential clocks
// RULE16 - Trigger channel zero is pattern LSB
// RULE17 - All sampling on rising user clock
// RULE18 - Stop and hold until re-armed
module ela_top
	import ela_pkg::*;
(
	input  wire logic              MCLK,
	input  wire logic              SRST,
	input  wire logic              CE,
	input  wire logic [TRIG_W-1:0] TRIG_IN,
	input  wire logic [MON_W-1:0]  MON_IN,
	output logic [STIM_W-1:0]      STIM_OUT,
	output logic                   STIM_VALID,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [11:0]       PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic [31:0]            PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR
);
	// ********************************************************
	// Registers
	// ********************************************************
	ela_trig_s       trig_reg [NSTAGE];
	logic [1:0]      nseq_reg;
	logic [6:0]      pre_reg;
	logic [STIM_W-1:0] stim_reg;
	logic [AW-1:0]   rdidx_reg;
	logic            arm_pulse;
	ela_state_e      st_reg;
	logic [1:0]      stage_reg;
	logic [AW-1:0]   wptr_reg;
	logic [AW:0]     cnt_reg;
	logic [AW-1:0]   trig_ptr_reg;
	logic [TRIG_W-1:0] prev_reg;
	logic            stim_sent_reg;
	ela_sample_s     mem [DEPTH];
	ela_sample_s     rd_reg;
	logic [NSTAGE-1:0] hit;
	logic            last_hit;
	logic            wr_en;
	logic [AW:0]     pre_cnt;
	logic [AW:0]     post_cnt;
	logic [AW:0]     pre_raw;
	logic [AW-1:0]   rd_addr;
	logic            acc;
	logic            wr;

	// RULE1 RULE5: stimulus width fixed by package constant
	if (STIM_W > STIM_MAX_W)
	begin : g_stim_w_check
		$error("stimulus width too large");
	end

	// ********************************************************
	// Bus handshake
	// ********************************************************
	// Zero wait states: every access completes in its access cycle
	assign acc = PSEL & PENABLE & CE;
	assign wr  = acc & PWRITE;
	assign PREADY  = 1'b1;
	assign PSLVERR = 1'b0;
	assign arm_pulse = wr && PADDR == OFS_CTRL && PWDATA[CTRL_ARM_BIT];

	// ********************************************************
	// Trigger stages
	// ********************************************************
	for (genvar g = 0; g < NSTAGE; g++)
	begin : g_stage
		ela_stage u_stage
		(
			.cur (TRIG_IN),
			.prv (prev_reg),
			.cfg (trig_reg[g]),
			.hit (hit[g])
		);
	end

	// Only the armed phase may end the sequence; pre-fill never triggers
	assign last_hit = (st_reg == ST_ARMED) && hit[stage_reg] &&
		(stage_reg == nseq_reg - 2'h1); // RULE15

	// Pre-trigger sample count from percentage of built-in depth
	assign pre_raw  = (AW+1)'((DEPTH * int'(pre_reg)) / 100); // RULE8 RULE7
	// A full pre-store still leaves one slot for the trigger sample
	assign pre_cnt  = (pre_raw == (AW+1)'(DEPTH)) ? pre_raw - (AW+1)'(1) : pre_raw;
	assign post_cnt = (AW+1)'(DEPTH) - pre_cnt; // RULE8

	// ********************************************************
	// Register writes
	// ********************************************************
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			nseq_reg  <= NSEQ_RST;
			pre_reg   <= PRE_RST;
			stim_reg  <= '0;
			rdidx_reg <= '0;
			for (int s = 0; s < NSTAGE; s++)
				trig_reg[s] <= '0;
		end
		else if (wr)
		begin
			case (PADDR)
				OFS_CTRL:
				begin
					// A stage count of 0 is taken as 1
					nseq_reg <= (PWDATA[CTRL_NSEQ_LSB +: 2] == 2'h0) ? 2'h1 :
						(PWDATA[CTRL_NSEQ_LSB +: 2] == 2'h3) ? 2'h3 :
						PWDATA[CTRL_NSEQ_LSB +: 2];
					for (int s = 0; s < NSTAGE; s++)
						trig_reg[s].use_or <= PWDATA[CTRL_OR_LSB + s]; // RULE12
				end
				// Percent clamps on the whole word, so 200 reads back as 100
				OFS_PRE:   pre_reg   <= (PWDATA > 32'h0000_0064) ? 7'h64 : PWDATA[6:0];
				OFS_STIM:  stim_reg  <= PWDATA[STIM_W-1:0]; // RULE13
				OFS_RDIDX: rdidx_reg <= PWDATA[AW-1:0];
				default:
				begin
					for (int s = 0; s < NSTAGE; s++)
					begin
						// RULE16: channel 0 maps to bit 0 of each mask
						if (PADDR == OFS_TRIG + 12'(s * TRIG_STRIDE) + 12'(TOF_PAT_LO))
							trig_reg[s].pat[31:0] <= PWDATA;
						if (PADDR == OFS_TRIG + 12'(s * TRIG_STRIDE) + 12'(TOF_PAT_HI))
							trig_reg[s].pat[TRIG_W-1:32] <= PWDATA[TRIG_W-33:0];
						if (PADDR == OFS_TRIG + 12'(s * TRIG_STRIDE) + 12'(TOF_EDG_LO))
							trig_reg[s].edg[31:0] <= PWDATA;
						if (PADDR == OFS_TRIG + 12'(s * TRIG_STRIDE) + 12'(TOF_EDG_HI))
							trig_reg[s].edg[TRIG_W-1:32] <= PWDATA[TRIG_W-33:0];
						if (PADDR == OFS_TRIG + 12'(s * TRIG_STRIDE) + 12'(TOF_CARE_LO))
							trig_reg[s].care[31:0] <= PWDATA;
						if (PADDR == OFS_TRIG + 12'(s * TRIG_STRIDE) + 12'(TOF_CARE_HI))
							trig_reg[s].care[TRIG_W-1:32] <= PWDATA[TRIG_W-33:0];
					end
				end
			endcase
		end
	end

	// ********************************************************
	// Capture sequencer
	// ********************************************************
	always_ff @(posedge MCLK) // RULE17
	begin
		if (SRST)
		begin
			st_reg       <= ST_IDLE;
			stage_reg    <= 2'h0;
			wptr_reg     <= '0;
			cnt_reg      <= '0;
			trig_ptr_reg <= '0;
			prev_reg     <= '0;
		end
		else if (CE)
		begin
			// Previous trigger word feeds the edge detectors
			prev_reg <= TRIG_IN;
			if (arm_pulse)
			begin
				// Re-arm restarts capture from a clean buffer pointer
				st_reg    <= (pre_cnt == '0) ? ST_ARMED : ST_PRE; // RULE18
				stage_reg <= 2'h0;
				wptr_reg  <= '0;
				cnt_reg   <= '0;
			end
			else
			begin
				case (st_reg)
					ST_PRE:
					begin
						wptr_reg <= wptr_reg + 1'b1;
						cnt_reg  <= cnt_reg + 1'b1;
						if (cnt_reg + 1'b1 == pre_cnt)
							st_reg <= ST_ARMED;
					end
					ST_ARMED:
					begin
						// Pointer runs free while armed with a nonzero pre-store; newest samples replace oldest
						if (pre_cnt != '0)
							wptr_reg <= wptr_reg + 1'b1;
						if (last_hit)
						begin
							st_reg       <= ST_POST;
							trig_ptr_reg <= wptr_reg;
							wptr_reg     <= wptr_reg + 1'b1;
							cnt_reg      <= (AW+1)'(1);
							if (post_cnt == (AW+1)'(1))
								st_reg <= ST_DONE;
						end
						// Next stage is looked at from the following clock
						else if (hit[stage_reg])
							stage_reg <= stage_reg + 2'h1; // RULE15
					end
					ST_POST:
					begin
						wptr_reg <= wptr_reg + 1'b1;
						cnt_reg  <= cnt_reg + 1'b1;
						if (cnt_reg + 1'b1 == post_cnt)
							st_reg <= ST_DONE; // RULE18
					end
					ST_IDLE, ST_DONE: ;
					default: st_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ********************************************************
	// Trace buffer
	// ********************************************************
	// Pre-store marker high before trigger, low from trigger sample on
	assign wr_en = CE && !arm_pulse &&
		(st_reg == ST_PRE || st_reg == ST_ARMED || st_reg == ST_POST); // RULE4

	always_ff @(posedge MCLK)
	begin
		if (wr_en)
			mem[wptr_reg] <= '{data: MON_IN, mark: (st_reg != ST_POST) && !last_hit}; // RULE6 RULE9
	end

	// Index 0 is the oldest kept sample; the fetch is registered
	assign rd_addr = rdidx_reg + trig_ptr_reg - AW'(pre_cnt);

	always_ff @(posedge MCLK)
	begin
		if (CE)
			rd_reg <= mem[rd_addr];
	end

	// ********************************************************
	// Stimulus output
	// ********************************************************
	// One strobe per arming, a cycle after the arm write
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			STIM_OUT      <= '0;
			STIM_VALID    <= 1'b0;
			stim_sent_reg <= 1'b0;
		end
		else if (CE)
		begin
			// Strobe stands for one CE-enabled cycle only; it holds while CE is low
			STIM_VALID <= 1'b0; // RULE3
			if (arm_pulse)
				stim_sent_reg <= 1'b0;
			else if (!stim_sent_reg && st_reg != ST_IDLE)
			begin
				STIM_OUT      <= stim_reg; // RULE13
				STIM_VALID    <= 1'b1; // RULE2 RULE3
				stim_sent_reg <= 1'b1; // RULE2
			end
		end
	end

	// ********************************************************
	// Read mux
	// ********************************************************
	// Unmapped addresses read as zero
	always_comb
	begin
		PRDATA = 32'h0000_0000;
		case (PADDR)
			OFS_CTRL:   PRDATA = {25'h0, trig_reg[2].use_or, trig_reg[1].use_or,
				trig_reg[0].use_or, 1'b0, nseq_reg, 1'b0};
			OFS_STATUS: PRDATA = {27'h0, stage_reg, 3'(st_reg)};
			OFS_PRE:    PRDATA = {25'h0, pre_reg};
			OFS_STIM:   PRDATA = stim_reg;
			OFS_RDIDX:  PRDATA = {22'h0, rdidx_reg};
			OFS_RDDATA: PRDATA = rd_reg.data;
			OFS_RDMARK: PRDATA = {31'h0, rd_reg.mark};
			OFS_DEPTH:  PRDATA = 32'(DEPTH); // RULE7
			default:    PRDATA = 32'h0000_0000;
		endcase
	end
endmodule
`default_nettype wire

/* tb/ela_properties.sv */
// Checker bound to ela_top: stimulus strobe and register reads.
// Assumes zero-wait APB, writes taken while CE is high.
`timescale 1ns/1ns
`default_nettype none
module ela_properties
	import ela_pkg::*;
(
	input wire logic              MCLK,
	input wire logic              SRST,
	input wire logic              CE,
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PWRITE,
	input wire logic [11:0]       PADDR,
	input wire logic [31:0]       PWDATA,
	input wire logic [31:0]       PRDATA,
	input wire logic [STIM_W-1:0] STIM_OUT,
	input wire logic              STIM_VALID
);
	logic rd;
	logic arm;
	assign rd = PSEL && PENABLE && !PWRITE;
	assign arm = PSEL && PENABLE && PWRITE && CE && PADDR == OFS_CTRL && PWDATA[0];
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	a_stim_one_cycle: assert property (STIM_VALID |=> !STIM_VALID)
		else $error("strobe too long");
	a_stim_after_arm: assert property ($rose(STIM_VALID) |-> $past(arm) || $past(arm, 2))
		else $error("strobe without arm");
	a_arm_stim: assert property (arm |-> ##[1:2] STIM_VALID)
		else $error("arm without strobe");
	a_depth_fixed: assert property (rd && PADDR == OFS_DEPTH |-> PRDATA == DEPTH)
		else $error("depth wrong");
	a_pre_clamp: assert property (rd && PADDR == OFS_PRE |-> PRDATA <= 32'h64)
		else $error("fraction over range");
	a_state_code: assert property (rd && PADDR == OFS_STATUS |-> PRDATA[2:0] <= 3'h4)
		else $error("bad state code");
	a_stage_code: assert property (rd && PADDR == OFS_STATUS |-> PRDATA[4:3] <= 2'h2)
		else $error("bad stage code");
	a_mark_bit: assert property (rd && PADDR == OFS_RDMARK |-> PRDATA[31:1] == 31'h0)
		else $error("marker not one bit");
	c_strobe: cover property (STIM_VALID);
	c_arm: cover property (arm);
	c_read: cover property (rd && PADDR == OFS_RDDATA);
endmodule
bind ela_top ela_properties u_props (.MCLK, .SRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PRDATA, .STIM_OUT, .STIM_VALID);
`default_nettype wire

/* tb/ela_user_model.sv */
// Model of the user design: counts on the probe buses, keeps the stimulus.
// Assumes the analyzer samples both buses on the rising clock.
`timescale 1ns/1ns
`default_nettype none
module ela_user_model
	import ela_pkg::*;
(
	input  wire logic              MCLK,
	input  wire logic              SRST,
	input  wire logic [STIM_W-1:0] STIM_OUT,
	input  wire logic              STIM_VALID,
	output logic [TRIG_W-1:0]      TRIG_IN,
	output logic [MON_W-1:0]       MON_IN,
	output logic [STIM_W-1:0]      taken
);
	logic [31:0] cnt_reg;
	always_ff @(posedge MCLK)
		cnt_reg <= SRST ? 32'h0 : cnt_reg + 32'h1;
	assign MON_IN = cnt_reg;
	assign TRIG_IN = {8'h00, cnt_reg};
	// Bus ignored unless the strobe is high
	always_ff @(posedge MCLK)
		if (STIM_VALID)
			taken <= STIM_OUT;
endmodule
`default_nettype wire

/* tb/ela_top_bench.sv */
// Bench for ela_top: register reads, stimulus strobe, two capture runs.
// Assumes the user model counts on the trigger and probe buses.
`timescale 1ns/1ns
`default_nettype none
module ela_top_bench
	import ela_pkg::*;
;
	logic MCLK = 1'b0, SRST = 1'b1, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, q;
	logic PREADY, PSLVERR, STIM_VALID, err;
	logic [TRIG_W-1:0] TRIG_IN;
	logic [MON_W-1:0] MON_IN;
	logic [STIM_W-1:0] STIM_OUT, taken;
	int fail_count = 0, n_compared = 0, npul = 0;
	ela_top DUT (.MCLK, .SRST, .CE, .TRIG_IN, .MON_IN, .STIM_OUT, .STIM_VALID, .PSEL,
		.PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
	ela_user_model u_user (.MCLK, .SRST, .STIM_OUT, .STIM_VALID, .TRIG_IN, .MON_IN, .taken);
	initial forever #4 MCLK = ~MCLK;
	always @(posedge MCLK) npul += int'(STIM_VALID);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask
	task automatic wrap_up(input bit hung);
		if (hung)
			fail_count++;
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		n = 0;
		do
		begin
			@(posedge MCLK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 50);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (PREADY !== 1'b1)
			wrap_up(1'b1);
		@(posedge MCLK);
	endtask
	// Six mask words of one stage, in register order
	task automatic stage(input int s, input logic [31:0] v [6]);
		for (int k = 0; k < 6; k++)
			apb(1'b1, OFS_TRIG + 12'(s * TRIG_STRIDE + 4 * k), v[k]);
	endtask
	task automatic regs;
		chk("stim_out", STIM_OUT, 32'h0);
		apb(1'b0, OFS_DEPTH, 32'h0);
		chk("depth", q, DEPTH);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", q & 32'h7, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", q, 32'h0);
		chk("slverr", 32'(err), 32'h0);
		apb(1'b0, OFS_PRE, 32'h0);
		chk("pre", q, 32'(PRE_RST));
		apb(1'b1, OFS_PRE, 32'hC8);
		apb(1'b0, OFS_PRE, 32'h0);
		chk("pre_max", q, 32'h64);
		// Writes while the clock enable is low must be dropped
		CE <= 1'b0;
		apb(1'b1, OFS_PRE, 32'h32);
		CE <= 1'b1;
		apb(1'b0, OFS_PRE, 32'h0);
		chk("pre_frozen", q, 32'h64);
	endtask
	task automatic run(input int pre, input logic [31:0] ctl, stim, input bit nchk,
		input logic [3:0] nib);
		logic [31:0] b0;
		int pn;
		int n;
		pn = pre * DEPTH / 100;
		apb(1'b1, OFS_PRE, 32'(pre));
		apb(1'b1, OFS_STIM, stim);
		npul = 0;
		apb(1'b1, OFS_CTRL, ctl);
		n = 0;
		do
		begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end
		while (q[2:0] !== 3'h4 && n < 2000);
		if (q[2:0] !== 3'h4)
			wrap_up(1'b1);
		chk("pulses", 32'(npul), 32'h1);
		chk("stim", taken, stim);
		for (int i = 0; i < DEPTH; i++)
		begin
			apb(1'b1, OFS_RDIDX, 32'(i));
			repeat (2) @(posedge MCLK);
			apb(1'b0, OFS_RDDATA, 32'h0);
			if (i == 0)
				b0 = q;
			chk("sample", q, b0 + 32'(i));
			if (nchk && i == pn)
				chk("trigger", q & 32'hF, 32'(nib));
			apb(1'b0, OFS_RDMARK, 32'h0);
			chk("mark", q, 32'(i < pn));
		end
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("held", q & 32'h7, 32'h4);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", q, ctl & 32'h0000_0076);
	endtask
	initial
	begin
		repeat (3) @(posedge MCLK);
		SRST <= 1'b0;
		@(posedge MCLK);
		regs();
		stage(0, '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0});
		run(0, 32'h3, 32'hA5C30F1E, 1'b0, 4'h0);
		// Stage 0 AND on level F, stage 1 OR of a fall and a dead channel
		stage(0, '{32'hF, 32'h0, 32'h0, 32'h0, 32'hF, 32'h0});
		stage(1, '{32'h0, 32'h80, 32'h1, 32'h0, 32'h1, 32'h80});
		run(25, 32'h25, 32'h5A3CF0E1, 1'b1, 4'h0);
		wrap_up(1'b0);
	end
endmodule
`default_nettype wire
